// ==== rtl/tpo_pkg.sv ====
// Purpose: Shared constants, types and register map of the timing pulse output generator
// Assumes: 10 MHz pclk; external time base gives UTC seconds and nanoseconds within the second
// Notes:   One output signal (the coaxial connector); every number used by the design lives here
package tpo_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ     = 32'h0098_9680;
  localparam int unsigned NS_PER_SEC = 32'h3B9A_CA00;
  localparam int unsigned CLK_NS     = NS_PER_SEC / CLK_HZ;
  localparam int unsigned PIPE_CYC   = 32'h0000_0002;
  localparam int unsigned LEAD_NS    = PIPE_CYC * CLK_NS;

  localparam int unsigned NS_W  = 30;
  localparam int unsigned SEC_W = 32;
  localparam int unsigned PER_W = 17;
  localparam int unsigned DLY_W = 32;
  localparam int unsigned PH_W  = 34;
  localparam int unsigned CNT_W = 24;

  // Phase window, in ns of the shifted second, in which a pulse is launched
  localparam logic signed [PH_W-1:0] PH_SEC     = PH_W'(NS_PER_SEC);
  localparam logic signed [PH_W-1:0] PH_FIRE_LO = PH_W'(NS_PER_SEC - LEAD_NS);
  localparam logic signed [PH_W-1:0] PH_FIRE_HI = PH_W'(NS_PER_SEC - LEAD_NS + CLK_NS);

  // Register byte offsets
  localparam logic [7:0] OFS_OUT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_OUT_WIDTH = 8'h04;
  localparam logic [7:0] OFS_OUT_DELAY = 8'h08;
  localparam logic [7:0] OFS_PER_PER   = 8'h0C;
  localparam logic [7:0] OFS_PER_VALUE = 8'h10;
  localparam logic [7:0] OFS_PER_WIDTH = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // Output control fields
  localparam int unsigned FORM_W       = 3;
  localparam int unsigned SEL_W        = 2;
  localparam int unsigned CTRL_FORM_LSB = 0;
  localparam int unsigned CTRL_INV_BIT  = 3;
  localparam int unsigned CTRL_SEL_LSB  = 4;
  localparam logic [SEL_W-1:0] SEL_ALL = 2'h0;
  localparam logic [SEL_W-1:0] SEL_BNC = 2'h1;

  // Status fields
  localparam int unsigned ST_LEVEL    = 0;
  localparam int unsigned ST_STD_BUSY = 1;
  localparam int unsigned ST_PER_BUSY = 2;
  localparam int unsigned ST_REFUSED  = 3;
  localparam int unsigned ST_REF_SEL  = 4;

  // Limits
  localparam logic [PER_W-1:0]        PER_MIN    = 17'h0_0002;
  localparam logic [PER_W-1:0]        PER_MAX    = 17'h1_86A0;
  localparam logic [NS_W-1:0]         PW_MIN_NS  = 30'h0000_0064;
  localparam logic [NS_W-1:0]         PW_MAX_NS  = 30'h1DCD_6500;
  localparam logic signed [DLY_W-1:0] DLY_MAX_NS = 32'sh3B9A_C99C;

  // Output forms
  typedef enum logic [FORM_W-1:0] {
    FORM_OFF      = 3'h0,
    FORM_LOW      = 3'h1,
    FORM_HIGH     = 3'h2,
    FORM_PPS      = 3'h3,
    FORM_EVEN     = 3'h4,
    FORM_10MHZ    = 3'h5,
    FORM_PERIODIC = 3'h6
  } tpo_form_t;

  // Forms the coaxial output supports, one bit per form code
  localparam logic [7:0] BNC_FORMS = 8'h7F;

  typedef struct packed {
    tpo_form_t                form;
    logic                     invert;
    logic [NS_W-1:0]          width;
    logic signed [DLY_W-1:0]  delay;
  } tpo_out_cfg_t;

  typedef struct packed {
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] value;
    logic [NS_W-1:0]  width;
  } tpo_per_cfg_t;

  // Reset values
  localparam tpo_form_t               RST_FORM      = FORM_OFF;
  localparam logic                    RST_INV       = 1'h0;
  localparam logic [NS_W-1:0]         RST_WIDTH     = 30'h0001_86A0;
  localparam logic signed [DLY_W-1:0] RST_DELAY     = 32'sh0000_0000;
  localparam logic [PER_W-1:0]        RST_PERIOD    = 17'h0_0002;
  localparam logic [PER_W-1:0]        RST_VALUE     = 17'h0_0000;
  localparam logic [NS_W-1:0]         RST_PER_WIDTH = 30'h0001_86A0;

endpackage : tpo_pkg

// ==== rtl/tpo_pulse_timer.sv ====
// Purpose: Holds a pulse for a programmed width in ns, rounded up to whole clock cycles
// Assumes: width_ns is at least one clock period
// Notes:   Width is latched at start; a new start restarts the pulse
`timescale 1ns/1ps
module tpo_pulse_timer
  import tpo_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            start,
  input  wire logic [NS_W-1:0] width_ns,
  output logic                 busy
);

  logic [CNT_W-1:0] cnt_r;
  logic [NS_W-1:0]  sum;
  logic [CNT_W-1:0] cycles;

  always_comb begin
    sum    = width_ns + NS_W'(CLK_NS - 1);
    cycles = CNT_W'(sum / NS_W'(CLK_NS));
    if (cycles == '0) begin
      cycles = CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= cycles;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  assign busy = (cnt_r != '0);

endmodule : tpo_pulse_timer

// ==== rtl/tpo_gen.sv ====
// Purpose: Timing pulse output generator with APB register access
// Assumes: tb_ns steps by one clock period each cycle and wraps at one second; tb_sec is UTC seconds
// Notes:   Output edges land on the first clock edge at or after the shifted time base crosses the target ns
//
// How it works
// - Seven output forms selectable by control register
// - Select all applies setting to every output
// - Unsupported form leaves output configuration unchanged
// - Invert flips output level in every form but off
// - Own width for pulses; periodic uses its own
// - Signed ns delay shifts pulse earlier or later
// - Delay moves only the pulse, never time base
// - Delay change acts on output at once
// - Pulses align to UTC seconds from time base
// - Period in whole seconds, 2 to 100000
// - Pulse on second count modulo period equal to value
// - Periodic width 100 ns to half second
`timescale 1ns/1ps
module tpo_gen
  import tpo_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NS_W-1:0]  tb_ns,
  input  wire logic [SEC_W-1:0] tb_sec,
  output logic                  tpo_out,
  output logic                  tpo_out_en,
  output logic                  tpo_ref_sel
);

  tpo_out_cfg_t     out_cfg_r;
  tpo_per_cfg_t     per_cfg_r;
  logic             refused_r;
  logic [31:0]      prdata_r;
  logic             out_r;
  logic             out_en_r;
  logic             ref_sel_r;

  logic             setup_rd;
  logic             access;
  logic             wr_en;
  logic             mapped;
  logic             wr_bad;
  logic [31:0]      rd_val;

  logic [FORM_W-1:0]       wr_form;
  logic                    wr_inv;
  logic [SEL_W-1:0]        wr_sel;
  logic                    ctrl_hit;
  logic                    form_ok;
  logic [NS_W-1:0]         wr_ns;
  logic [PER_W-1:0]        wr_per;
  logic signed [DLY_W-1:0] wr_dly;

  logic signed [PH_W-1:0]  ph_raw;
  logic signed [PH_W-1:0]  ph_adj;
  logic [SEC_W-1:0]        sec_tgt;
  logic [PER_W-1:0]        sec_mod;
  logic                    fire;
  logic                    std_start;
  logic                    per_start;
  logic                    std_busy;
  logic                    per_busy;
  logic                    lvl_nxt;
  logic                    en_nxt;
  logic                    ref_nxt;

  // APB decode
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access   = psel & penable;
  assign wr_en    = access & pwrite & ~wr_bad;
  assign pready   = 1'b1;
  assign pslverr  = access & (~mapped | (pwrite & wr_bad));
  assign prdata   = prdata_r;

  assign wr_form  = pwdata[CTRL_FORM_LSB +: FORM_W];
  assign wr_inv   = pwdata[CTRL_INV_BIT];
  assign wr_sel   = pwdata[CTRL_SEL_LSB +: SEL_W];
  assign wr_ns    = pwdata[NS_W-1:0];
  assign wr_per   = pwdata[PER_W-1:0];
  assign wr_dly   = $signed(pwdata);

  // Select all or the coaxial output; other selections reach no output
  assign ctrl_hit = (wr_sel == SEL_ALL) | (wr_sel == SEL_BNC);
  assign form_ok  = BNC_FORMS[wr_form];

  always_comb begin
    mapped = 1'b1;
    wr_bad = 1'b0;
    if (pstrb != 4'hF) begin
      wr_bad = 1'b1;
    end
    unique case (paddr)
      OFS_OUT_CTRL: begin
        if (!ctrl_hit || !form_ok || pwdata[31:CTRL_SEL_LSB+SEL_W] != '0) begin
          wr_bad = 1'b1;
        end
      end
      OFS_OUT_WIDTH: begin
        if (pwdata[31:NS_W] != '0 || wr_ns < PW_MIN_NS || wr_ns > PW_MAX_NS) begin
          wr_bad = 1'b1;
        end
      end
      OFS_OUT_DELAY: begin
        if (wr_dly > DLY_MAX_NS || wr_dly < -DLY_MAX_NS) begin
          wr_bad = 1'b1;
        end
      end
      OFS_PER_PER: begin
        if (pwdata[31:PER_W] != '0 || wr_per < PER_MIN || wr_per > PER_MAX) begin
          wr_bad = 1'b1;
        end
      end
      OFS_PER_VALUE: begin
        if (pwdata[31:PER_W] != '0 || wr_per >= per_cfg_r.period) begin
          wr_bad = 1'b1;
        end
      end
      OFS_PER_WIDTH: begin
        if (pwdata[31:NS_W] != '0 || wr_ns < PW_MIN_NS || wr_ns > PW_MAX_NS) begin
          wr_bad = 1'b1;
        end
      end
      OFS_STATUS: begin
        wr_bad = 1'b1;
      end
      default: begin
        mapped = 1'b0;
        wr_bad = 1'b1;
      end
    endcase
  end

  // Output configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cfg_r.form   <= RST_FORM;
      out_cfg_r.invert <= RST_INV;
      out_cfg_r.width  <= RST_WIDTH;
      out_cfg_r.delay  <= RST_DELAY;
    end else if (wr_en) begin
      if (paddr == OFS_OUT_CTRL) begin
        out_cfg_r.form   <= tpo_form_t'(wr_form);
        out_cfg_r.invert <= wr_inv;
      end
      if (paddr == OFS_OUT_WIDTH) begin
        out_cfg_r.width <= wr_ns;
      end
      if (paddr == OFS_OUT_DELAY) begin
        out_cfg_r.delay <= wr_dly;
      end
    end
  end

  // Periodic configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cfg_r.period <= RST_PERIOD;
      per_cfg_r.value  <= RST_VALUE;
      per_cfg_r.width  <= RST_PER_WIDTH;
    end else if (wr_en) begin
      if (paddr == OFS_PER_PER) begin
        per_cfg_r.period <= wr_per;
        if (per_cfg_r.value >= wr_per) begin
          per_cfg_r.value <= RST_VALUE;
        end
      end
      if (paddr == OFS_PER_VALUE) begin
        per_cfg_r.value <= wr_per;
      end
      if (paddr == OFS_PER_WIDTH) begin
        per_cfg_r.width <= wr_ns;
      end
    end
  end

  // Outcome of the last write access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_r <= 1'b0;
    end else if (access & pwrite) begin
      refused_r <= wr_bad;
    end
  end

  // Read data captured in the setup cycle
  always_comb begin
    rd_val = '0;
    unique case (paddr)
      OFS_OUT_CTRL: begin
        rd_val[CTRL_FORM_LSB +: FORM_W] = out_cfg_r.form;
        rd_val[CTRL_INV_BIT]            = out_cfg_r.invert;
      end
      OFS_OUT_WIDTH: begin
        rd_val[NS_W-1:0] = out_cfg_r.width;
      end
      OFS_OUT_DELAY: begin
        rd_val = out_cfg_r.delay;
      end
      OFS_PER_PER: begin
        rd_val[PER_W-1:0] = per_cfg_r.period;
      end
      OFS_PER_VALUE: begin
        rd_val[PER_W-1:0] = per_cfg_r.value;
      end
      OFS_PER_WIDTH: begin
        rd_val[NS_W-1:0] = per_cfg_r.width;
      end
      OFS_STATUS: begin
        rd_val[ST_LEVEL]    = out_r;
        rd_val[ST_STD_BUSY] = std_busy;
        rd_val[ST_PER_BUSY] = per_busy;
        rd_val[ST_REFUSED]  = refused_r;
        rd_val[ST_REF_SEL]  = ref_sel_r;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_rd) begin
      prdata_r <= rd_val;
    end
  end

  // Shifted phase; the time base inputs are only read, never adjusted
  always_comb begin
    ph_raw  = $signed({4'h0, tb_ns}) - $signed({{2{out_cfg_r.delay[DLY_W-1]}}, out_cfg_r.delay});
    ph_adj  = ph_raw;
    sec_tgt = tb_sec + SEC_W'(1);
    if (ph_raw < 0) begin
      ph_adj  = ph_raw + PH_SEC;
      sec_tgt = tb_sec;
    end else if (ph_raw >= PH_SEC) begin
      ph_adj  = ph_raw - PH_SEC;
      sec_tgt = tb_sec + SEC_W'(2);
    end
  end

  // Launch two cycles ahead so the output edge meets the shifted UTC second
  assign fire    = (ph_adj >= PH_FIRE_LO) & (ph_adj < PH_FIRE_HI);
  assign sec_mod = PER_W'(sec_tgt % SEC_W'(per_cfg_r.period));

  assign std_start = fire & ((out_cfg_r.form == FORM_PPS) |
                             ((out_cfg_r.form == FORM_EVEN) & ~sec_tgt[0]));
  assign per_start = fire & (out_cfg_r.form == FORM_PERIODIC) & (sec_mod == per_cfg_r.value);

  tpo_pulse_timer u_std_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (std_start),
    .width_ns (out_cfg_r.width),
    .busy     (std_busy)
  );

  tpo_pulse_timer u_per_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (per_start),
    .width_ns (per_cfg_r.width),
    .busy     (per_busy)
  );

  // Output level per form
  always_comb begin
    lvl_nxt = 1'b0;
    en_nxt  = 1'b1;
    ref_nxt = 1'b0;
    unique case (out_cfg_r.form)
      FORM_OFF: begin
        en_nxt = 1'b0;
      end
      FORM_LOW: begin
        lvl_nxt = 1'b0;
      end
      FORM_HIGH: begin
        lvl_nxt = 1'b1;
      end
      FORM_PPS, FORM_EVEN: begin
        lvl_nxt = std_busy;
      end
      FORM_10MHZ: begin
        ref_nxt = 1'b1;
      end
      FORM_PERIODIC: begin
        lvl_nxt = per_busy;
      end
      default: begin
        en_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r     <= 1'b0;
      out_en_r  <= 1'b0;
      ref_sel_r <= 1'b0;
    end else begin
      out_r     <= en_nxt & (lvl_nxt ^ out_cfg_r.invert);
      out_en_r  <= en_nxt;
      ref_sel_r <= ref_nxt;
    end
  end

  assign tpo_out     = out_r;
  assign tpo_out_en  = out_en_r;
  assign tpo_ref_sel = ref_sel_r;

endmodule : tpo_gen

// ==== verif/tpo_gen_monitor.sv ====
// Purpose: Port assertions for the timing pulse output generator
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module tpo_gen_monitor
  import tpo_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [NS_W-1:0]  tb_ns,
  input wire logic [SEC_W-1:0] tb_sec,
  input wire logic             tpo_out,
  input wire logic             tpo_out_en,
  input wire logic             tpo_ref_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;

  strobe_refuse_a: assert property (wr_acc && pstrb != 4'hF |-> pslverr)
    else $error("partial strobe write taken");
  form_code_a: assert property (wr_acc && paddr == OFS_OUT_CTRL && pwdata[2:0] == 3'h7 |-> pslverr)
    else $error("form code 7 taken");
  sel_code_a: assert property (wr_acc && paddr == OFS_OUT_CTRL && pwdata[5:4] > 2'h1 |-> pslverr)
    else $error("unknown output select taken");
  en_hold_a: assert property ($changed(tpo_out_en) |-> $past(wr_acc && paddr == OFS_OUT_CTRL && !pslverr, 2))
    else $error("driver enable moved without accepted control write");
  ref_hold_a: assert property ($changed(tpo_ref_sel) |-> $past(wr_acc && paddr == OFS_OUT_CTRL, 2))
    else $error("reference select moved without control write");
  off_quiet_a: assert property (!tpo_out_en |-> !tpo_out && !tpo_ref_sel)
    else $error("output active while driver off");
  period_lim_a: assert property (wr_acc && paddr == OFS_PER_PER &&
    (pwdata < 32'h0000_0002 || pwdata > 32'h0001_86A0) |-> pslverr)
    else $error("period out of range taken");
  pwidth_lim_a: assert property (wr_acc && paddr == OFS_PER_WIDTH &&
    (pwdata < 32'h0000_0064 || pwdata > 32'h1DCD_6500) |-> pslverr)
    else $error("periodic width out of range taken");
  delay_ok_a: assert property (wr_acc && paddr == OFS_OUT_DELAY && pstrb == 4'hF &&
    $signed(pwdata) <= DLY_MAX_NS && $signed(pwdata) >= -DLY_MAX_NS |-> !pslverr)
    else $error("legal delay refused");

  cover property ($rose(tpo_out));
  cover property (wr_acc && pslverr);
  cover property ($rose(tpo_ref_sel));
endmodule : tpo_gen_monitor

// ==== verif/tpo_rx_model.sv ====
// Purpose: Receiver of the timing output, measures each pulse
// Assumes: inv tells the active level of the line
// Notes:   Records rise instant, pulse count and length in cycles
`timescale 1ns/1ps
module tpo_rx_model
  import tpo_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             inv,
  input  wire logic             tpo_out,
  input  wire logic             tpo_out_en,
  input  wire logic [NS_W-1:0]  tb_ns,
  input  wire logic [SEC_W-1:0] tb_sec,
  output logic      [NS_W-1:0]  rise_ns,
  output logic      [SEC_W-1:0] rise_sec,
  output int                    n_rise,
  output int                    hi_len
);
  logic act;
  logic act_r = 1'b0;
  assign act = tpo_out_en && (tpo_out ^ inv);
  initial begin
    n_rise = 0;
    hi_len = 0;
  end
  always @(posedge pclk) begin
    act_r <= act;
    if (act && !act_r) begin
      n_rise   <= n_rise + 1;
      rise_ns  <= tb_ns;
      rise_sec <= tb_sec;
      hi_len   <= 1;
    end else if (act) begin
      hi_len <= hi_len + 1;
    end
  end
endmodule : tpo_rx_model

// ==== verif/tpo_gen_bench.sv ====
// Purpose: Self-checking bench of the timing pulse output generator
// Assumes: Bench makes the time base; each pulse test restarts near a second's end
// Notes:   APB tasks with expected values
`timescale 1ns/1ps
module tpo_gen_bench
  import tpo_pkg::*;
;
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic             ld = 1'b1, inv = 1'b0, pready, pslverr, tpo_out, tpo_out_en, tpo_ref_sel;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, q;
  logic [3:0]       pstrb = 4'hF, strb = 4'hF;
  logic [NS_W-1:0]  tb_ns = '0, rise_ns;
  logic [SEC_W-1:0] tb_sec = '0, ld_sec = '0, rise_sec;
  int               n_rise, hi_len, n_errors = 0, tests_run = 0;

  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    if (ld) begin
      tb_ns  <= NS_W'(NS_PER_SEC - 32'h0000_2710);
      tb_sec <= ld_sec;
    end else if (tb_ns == NS_W'(NS_PER_SEC - CLK_NS)) begin
      tb_ns  <= '0;
      tb_sec <= tb_sec + 1'b1;
    end else tb_ns <= tb_ns + NS_W'(CLK_NS);
  end

  tpo_gen i_tpo_gen (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tb_ns(tb_ns), .tb_sec(tb_sec), .tpo_out(tpo_out), .tpo_out_en(tpo_out_en), .tpo_ref_sel(tpo_ref_sel));
  tpo_rx_model i_tpo_rx_model (.pclk(pclk), .inv(inv), .tpo_out(tpo_out), .tpo_out_en(tpo_out_en),
    .tb_ns(tb_ns), .tb_sec(tb_sec), .rise_ns(rise_ns), .rise_sec(rise_sec), .n_rise(n_rise), .hi_len(hi_len));

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic ee);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    q = prdata;
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    xfer(a, 1'b1, d, ee);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    xfer(a, 1'b0, 32'h0, ee);
    chk("prdata", exp, q);
  endtask : rd

  task automatic lvl(input logic [31:0] ctrl, input logic [2:0] exp, input logic ee);
    wr(OFS_OUT_CTRL, ctrl, ee);
    // Output register follows the control write one cycle later
    @(posedge pclk);
    @(negedge pclk);
    chk("out en ref", {29'h0, exp}, {29'h0, tpo_out, tpo_out_en, tpo_ref_sel});
  endtask : lvl

  task automatic sc(input string nm, input logic [SEC_W-1:0] s, input logic [31:0] ctrl, input logic [31:0] dly,
                    input logic [31:0] per, input logic [31:0] val, input logic [31:0] pw, input int en,
                    input logic [NS_W-1:0] ens, input int elen);
    int n0, k;
    @(posedge pclk);
    presetn <= 1'b0;
    ld      <= 1'b1;
    ld_sec  <= s;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ld      <= 1'b0;
    inv = ctrl[3];
    n0 = n_rise;
    k = 0;
    wr(OFS_OUT_CTRL, ctrl, 1'b0);
    wr(OFS_OUT_WIDTH, 32'h0000_012C, 1'b0);
    wr(OFS_PER_PER, per, 1'b0);
    wr(OFS_PER_VALUE, val, 1'b0);
    wr(OFS_PER_WIDTH, pw, 1'b0);
    wr(OFS_OUT_DELAY, dly, 1'b0);
    while (!(tb_sec == s + 1'b1 && tb_ns > 30'h0000_07D0) && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) begin
      n_errors++;
      give_verdict();
    end
    chk("pulse count", 32'(en), 32'(n_rise - n0));
    if (en > 0) begin
      chk("rise ns", 32'(ens), 32'(rise_ns));
      chk("rise sec", dly[31] ? s : s + 1'b1, rise_sec);
      chk("pulse cycles", 32'(elen), 32'(hi_len));
    end
    $display("Test %s done", nm);
  endtask : sc

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    ld      <= 1'b0;
    rd(OFS_OUT_WIDTH, 32'(RST_WIDTH), 1'b0);
    rd(OFS_PER_PER, 32'(RST_PERIOD), 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    wr(OFS_PER_PER, 32'h0000_0001, 1'b1);
    wr(OFS_PER_PER, 32'h0001_86A1, 1'b1);
    wr(OFS_PER_PER, 32'h0001_86A0, 1'b0);
    wr(OFS_PER_VALUE, 32'h0001_86A0, 1'b1);
    wr(OFS_PER_VALUE, 32'h0001_869F, 1'b0);
    wr(OFS_PER_WIDTH, 32'h0000_0063, 1'b1);
    wr(OFS_PER_WIDTH, 32'h1DCD_6501, 1'b1);
    wr(OFS_PER_WIDTH, 32'h0000_0064, 1'b0);
    rd(OFS_PER_WIDTH, 32'h0000_0064, 1'b0);
    strb = 4'h3;
    wr(OFS_OUT_WIDTH, 32'h0000_012C, 1'b1);
    strb = 4'hF;
    rd(OFS_OUT_WIDTH, 32'(RST_WIDTH), 1'b0);
    rd(OFS_STATUS, 32'h0000_0008, 1'b0);
    $display("Test registers done");
    lvl(32'h0000_0011, 3'b010, 1'b0);
    lvl(32'h0000_0002, 3'b110, 1'b0);
    lvl(32'h0000_000A, 3'b010, 1'b0);
    lvl(32'h0000_0009, 3'b110, 1'b0);
    lvl(32'h0000_0007, 3'b110, 1'b1);
    lvl(32'h0000_0021, 3'b110, 1'b1);
    lvl(32'h0000_0015, 3'b011, 1'b0);
    rd(OFS_OUT_CTRL, 32'h0000_0005, 1'b0);
    rd(OFS_STATUS, 32'h0000_0010, 1'b0);
    lvl(32'h0000_0000, 3'b000, 1'b0);
    $display("Test levels done");
    sc("pps", 5, 32'h3, 32'h0, 32'h2, 32'h0, 32'hC8, 1, '0, 3);
    sc("pps inv", 5, 32'hB, 32'h0, 32'h2, 32'h0, 32'hC8, 1, '0, 3);
    sc("early", 5, 32'h3, 32'hFFFF_FE0C, 32'h2, 32'h0, 32'hC8, 1, NS_W'(NS_PER_SEC - 32'h1F4), 3);
    sc("late", 5, 32'h3, 32'h2BC, 32'h2, 32'h0, 32'hC8, 1, 30'h2BC, 3);
    sc("even odd", 6, 32'h4, 32'h0, 32'h2, 32'h0, 32'hC8, 0, '0, 0);
    sc("even", 7, 32'h4, 32'h0, 32'h2, 32'h0, 32'hC8, 1, '0, 3);
    sc("per hit", 6, 32'h6, 32'h0, 32'h3, 32'h1, 32'hC8, 1, '0, 2);
    sc("per miss", 7, 32'h6, 32'h0, 32'h3, 32'h1, 32'hC8, 0, '0, 0);
    sc("per max", 99998, 32'h6, 32'h0, 32'h186A0, 32'h1869F, 32'h64, 1, '0, 1);
    give_verdict();
  end
endmodule : tpo_gen_bench

bind tpo_gen tpo_gen_monitor i_tpo_gen_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tb_ns(tb_ns), .tb_sec(tb_sec), .tpo_out(tpo_out), .tpo_out_en(tpo_out_en),
  .tpo_ref_sel(tpo_ref_sel));
